// file: verilog/asr_defs.vh
// constants of the serial receiver block
`ifndef ASR_DEFS_VH
`define ASR_DEFS_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASR_OFF_CTRL 8'h00
`define ASR_OFF_MODE 8'h04
`define ASR_OFF_DIV 8'h08
`define ASR_OFF_STAT 8'h0C
`define ASR_OFF_DATA 8'h10
`define ASR_OFF_PORT 8'h14
// ----------------------------------------
// control fields
// ----------------------------------------
`define ASR_CTRL_RE 0
`define ASR_CTRL_ASYNC 1
`define ASR_CTRL_RST 2'h2
// ----------------------------------------
// mode fields
// ----------------------------------------
`define ASR_MODE_CHR7 0
`define ASR_MODE_PEN 1
`define ASR_MODE_ODD 2
`define ASR_MODE_STOP2 3
`define ASR_MODE_MP 4
`define ASR_MODE_RST 5'h00
// ----------------------------------------
// status fields
// ----------------------------------------
`define ASR_ST_FULL 0
`define ASR_ST_ORER 1
`define ASR_ST_FER 2
`define ASR_ST_PER 3
`define ASR_ST_MPB 4
// ----------------------------------------
// bit period in pclk cycles, reset value
// ----------------------------------------
`define ASR_DIV_RST 16'h0364
`endif

// file: verilog/asr_buf2.v
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module asr_buf2 #(
  parameter W = 11,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  input wire pclk,
  input wire presetn,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  genvar g;

  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem_r[rp_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // ----------------------------------------
  // storage
  // ----------------------------------------
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_r[g] <= {W{1'b0}};
        end else if (push && wp_r == g[AW-1:0]) begin
          mem_r[g] <= in_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // pointers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= (wp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: verilog/asr_top.v
// serial receiver with error flags and apb registers
// How it works
// [R1] control bit picks synchronous or asynchronous; async resyncs on every start bit.
// [R2] frame: 7 or 8 data bits, 1 or 2 stop bits, even/odd/no parity.
// [R3] optional multiprocessor bit after data/parity is received and reported.
// [R4] parity, overrun and framing errors each have their own status flag.
// [R5] port register bit 0 reads the live receive pin level.
// [R6] stop bit sampled at frame end; zero sets the framing error flag.
// [R7] with two stop bits only the first is checked.
// [R8] a parity or framing errored character still lands in data register; full flag stays clear. An overrun character is dropped.
// [R9] no new character starts while a framing error flag is set.
// [R10] a flag clears by writing 0 after reading it as 1.
// [R11] reset, standby and module stop clear the flags.
// [R12] dropping receive enable leaves the error flags unchanged.
// [R13] parity mismatch against even/odd setting sets the parity error flag.
`include "asr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module asr_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rxd,
  input wire sck,
  input wire standby,
  input wire module_stop
);
  localparam W = 11;
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_MPB = 3'h4;
  localparam ST_STOP = 3'h5;
  localparam ST_SYNC = 3'h6;

  reg [1:0] serial_control_reg;
  reg [4:0] mode_r;
  reg [15:0] div_r;
  reg [7:0] rx_data_reg;
  reg rx_full_flag;
  reg orer_r;
  reg framing_error_flag;
  reg parity_error_flag;
  reg mpb_r;
  reg [4:0] arm_r;
  reg [2:0] st_r;
  reg [15:0] cnt_r;
  reg [2:0] bit_r;
  reg [7:0] sh_r;
  reg par_r;
  reg mpv_r;
  reg rxd_d_r;
  reg sck_d_r;
  reg [31:0] rd_mux;
  reg map_hit;

  wire rx_enable_bit = serial_control_reg[`ASR_CTRL_RE];
  wire async_mode = serial_control_reg[`ASR_CTRL_ASYNC];
  wire chr7 = mode_r[`ASR_MODE_CHR7];
  wire pen = mode_r[`ASR_MODE_PEN];
  wire odd = mode_r[`ASR_MODE_ODD];
  wire mpen = mode_r[`ASR_MODE_MP];
  wire stdby = standby | module_stop;
  wire acc = psel & penable & pready;
  wire wr_acc = acc & pwrite;
  wire rd_acc = acc & ~pwrite;
  wire sel_stat = (paddr == `ASR_OFF_STAT);
  wire tick = (cnt_r == 16'h0000);
  wire [2:0] last_bit = chr7 ? 3'h6 : 3'h7;
  wire [15:0] div_m1 = div_r - 16'h0001;
  wire [4:0] stat = {mpb_r, parity_error_flag, framing_error_flag, orer_r, rx_full_flag};
  wire [4:0] clr = (wr_acc && sel_stat) ? (arm_r & ~pwdata[4:0]) : 5'h00;

  // receiver to buffer
  reg push;
  reg [W-1:0] push_w;
  wire in_ready;
  wire out_valid;
  wire [W-1:0] out_w;
  wire out_ready = ~rx_full_flag & ~framing_error_flag & ~parity_error_flag;
  wire pop = out_valid & out_ready;
  wire ovr_set = push & ~in_ready;

  asr_buf2 #(
    .W(W),
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .flush(stdby),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(push_w),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data(out_w)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always @* begin
    map_hit = 1'b1;
    rd_mux = 32'h00000000;
    case (paddr)
      `ASR_OFF_CTRL: rd_mux[1:0] = serial_control_reg;
      `ASR_OFF_MODE: rd_mux[4:0] = mode_r;
      `ASR_OFF_DIV: rd_mux[15:0] = div_r;
      `ASR_OFF_STAT: rd_mux[4:0] = stat;
      `ASR_OFF_DATA: rd_mux[7:0] = rx_data_reg;
      `ASR_OFF_PORT: rd_mux[0] = rxd; // [R5]
      default: map_hit = 1'b0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~map_hit;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_mux;
      end else if (!psel) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_control_reg <= `ASR_CTRL_RST;
      mode_r <= `ASR_MODE_RST;
      div_r <= `ASR_DIV_RST;
    end else if (wr_acc) begin
      if (paddr == `ASR_OFF_CTRL) begin
        serial_control_reg <= pwdata[1:0];
      end
      if (paddr == `ASR_OFF_MODE) begin
        mode_r <= pwdata[4:0];
      end
      if (paddr == `ASR_OFF_DIV) begin
        div_r <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
    end
  end

  // flags seen as one by a status read arm their clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_r <= 5'h00;
    end else if (stdby) begin
      arm_r <= 5'h00;
    end else if (wr_acc && sel_stat) begin
      arm_r <= 5'h00;
    end else if (rd_acc && sel_stat) begin
      arm_r <= arm_r | prdata[4:0]; // [R10]
    end
  end

  // ----------------------------------------
  // status flags: set wins over clear
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_full_flag <= 1'b0;
      orer_r <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      mpb_r <= 1'b0;
      rx_data_reg <= 8'h00;
    end else if (stdby) begin
      rx_full_flag <= 1'b0; // [R11]
      orer_r <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      mpb_r <= 1'b0;
    end else begin
      if (pop) begin
        rx_data_reg <= out_w[7:0]; // [R8]
      end
      rx_full_flag <= (pop & ~out_w[8] & ~out_w[9]) | // [R8]
        (rx_full_flag & ~clr[`ASR_ST_FULL]);
      orer_r <= ovr_set | (orer_r & ~clr[`ASR_ST_ORER]); // [R4]
      framing_error_flag <= (pop & out_w[8]) | // [R6] [R10] [R12]
        (framing_error_flag & ~clr[`ASR_ST_FER]);
      parity_error_flag <= (pop & out_w[9]) | // [R13]
        (parity_error_flag & ~clr[`ASR_ST_PER]);
      if (pop) begin
        mpb_r <= out_w[10]; // [R3]
      end else if (clr[`ASR_ST_MPB]) begin
        mpb_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // receive word assembly
  // ----------------------------------------
  always @* begin
    push = 1'b0;
    push_w = {W{1'b0}};
    if (st_r == ST_STOP && tick) begin
      push = 1'b1;
      push_w[7:0] = chr7 ? {1'b0, sh_r[7:1]} : sh_r; // [R2]
      push_w[8] = ~rxd; // [R6] [R7]
      push_w[9] = pen & (par_r ^ odd); // [R13]
      push_w[10] = mpv_r; // [R3]
    end else if (st_r == ST_SYNC && sck && !sck_d_r && bit_r == 3'h7) begin
      push = 1'b1;
      push_w[7:0] = {rxd, sh_r[7:1]};
    end
  end

  // ----------------------------------------
  // receive sequencer
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cnt_r <= 16'h0000;
      bit_r <= 3'h0;
      sh_r <= 8'h00;
      par_r <= 1'b0;
      mpv_r <= 1'b0;
      rxd_d_r <= 1'b1;
      sck_d_r <= 1'b0;
    end else begin
      rxd_d_r <= rxd;
      sck_d_r <= sck;
      if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end
      if (stdby || !rx_enable_bit) begin
        st_r <= ST_IDLE; // [R12]
      end else begin
        case (st_r)
          ST_IDLE: begin
            bit_r <= 3'h0;
            par_r <= 1'b0;
            mpv_r <= 1'b0;
            if (!framing_error_flag && !parity_error_flag && !orer_r) begin // [R9]
              if (!async_mode) begin
                st_r <= ST_SYNC; // [R1]
              end else if (rxd_d_r && !rxd) begin
                st_r <= ST_START; // [R1]
                cnt_r <= {1'b0, div_r[15:1]};
              end
            end
          end
          ST_START: begin
            if (tick) begin
              st_r <= rxd ? ST_IDLE : ST_DATA;
              cnt_r <= div_m1;
            end
          end
          ST_DATA: begin
            if (tick) begin
              sh_r <= {rxd, sh_r[7:1]};
              par_r <= par_r ^ rxd;
              bit_r <= bit_r + 3'h1;
              cnt_r <= div_m1;
              if (bit_r == last_bit) begin
                st_r <= pen ? ST_PAR : (mpen ? ST_MPB : ST_STOP); // [R2]
              end
            end
          end
          ST_PAR: begin
            if (tick) begin
              par_r <= par_r ^ rxd; // [R13]
              cnt_r <= div_m1;
              st_r <= mpen ? ST_MPB : ST_STOP;
            end
          end
          ST_MPB: begin
            if (tick) begin
              mpv_r <= rxd; // [R3]
              cnt_r <= div_m1;
              st_r <= ST_STOP;
            end
          end
          ST_STOP: begin
            if (tick) begin
              st_r <= ST_IDLE; // [R7]
            end
          end
          ST_SYNC: begin
            if (async_mode) begin
              st_r <= ST_IDLE;
            end else if (sck && !sck_d_r) begin
              sh_r <= {rxd, sh_r[7:1]};
              bit_r <= bit_r + 3'h1;
              if (bit_r == 3'h7 && (framing_error_flag || orer_r)) begin
                st_r <= ST_IDLE;
              end
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: test/asr_line_model.sv
// serial line model that drives the receive pin
`timescale 1ns/1ps
`default_nettype none
module asr_line_model #(
  parameter int DIV = 16
) (
  input wire logic pclk,
  output logic rxd
);
  // idle line is pulled high
  initial rxd = 1'b1;
  // ----------------
  // f = {stop2, stop1, mp bit, bad parity}
  // ----------------
  task automatic send(input logic [4:0] m, input logic [7:0] d, input logic [3:0] f);
    logic b[$];
    b.push_back(1'b0);
    for (int i = 0; i < (m[0] ? 7 : 8); i++) b.push_back(d[i]);
    if (m[1]) b.push_back((m[0] ? ^d[6:0] : ^d) ^ m[2] ^ f[0]);
    if (m[4]) b.push_back(f[1]);
    b.push_back(f[2]);
    if (m[3]) b.push_back(f[3]);
    foreach (b[i]) begin
      rxd <= b[i];
      repeat (DIV) @(posedge pclk);
    end
    rxd <= 1'b1;
    // one idle cycle so a following call never drives the pin in the same step
    @(posedge pclk);
  endtask
  task automatic level(input logic v);
    rxd <= v;
  endtask
endmodule
`default_nettype wire

// file: test/asr_top_asserts.sv
// port checker for the serial receiver
`include "asr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module asr_top_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rxd,
  input wire logic standby,
  input wire logic module_stop
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire rd_stat = pready && !pwrite && paddr == `ASR_OFF_STAT;
  wire rd_port = pready && !pwrite && paddr == `ASR_OFF_PORT;
  logic rxd_r;
  logic [3:0] stab_r;
  // cycles the pin has held still
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_r <= 1'b1;
      stab_r <= 4'h0;
    end else begin
      rxd_r <= rxd;
      stab_r <= (rxd != rxd_r) ? 4'h0 : (stab_r == 4'hF ? stab_r : stab_r + 4'h1);
    end
  end
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_unmapped_err: assert property (pready && paddr > 8'h14 |-> pslverr)
    else $error("unmapped access not refused");
  a_err_idle: assert property (!pready |-> !pslverr)
    else $error("pslverr outside access");
  a_stat_upper: assert property (rd_stat |-> prdata[31:5] == 27'h0)
    else $error("status upper bits set");
  a_standby_clear: assert property (rd_stat && $past(standby, 2) |-> prdata[4:0] == 5'h0)
    else $error("flags survive standby");
  a_stop_clear: assert property (rd_stat && $past(module_stop, 2) |-> prdata[4:0] == 5'h0)
    else $error("flags survive module stop");
  a_port_live: assert property (rd_port && stab_r > 4'h8 |-> prdata == {31'h0, rxd_r})
    else $error("port read differs from pin");
endmodule
bind asr_top asr_top_asserts asr_top_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxd(rxd), .standby(standby), .module_stop(module_stop));
`default_nettype wire

// file: test/test_async_serial_receiver_errors.sv
// self-checking bench for the serial receiver
`include "asr_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module test_async_serial_receiver_errors;
  localparam int DIV = 16;
  logic pclk, presetn, psel, penable, pwrite, standby, module_stop, pready, pslverr, rxd;
  logic sck, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  int fails = 0;
  int compares = 0;
  int cyc = 0;
  asr_top asr_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .sck(sck), .standby(standby), .module_stop(module_stop));
  asr_line_model #(.DIV(DIV)) asr_line_model_inst (.pclk(pclk), .rxd(rxd));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ----------------
  // bus and compare tasks
  // ----------------
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), r, e);
  endtask
  // one frame, then status and data checks
  task automatic rx(input logic [4:0] m, input logic [7:0] d, input logic [3:0] f,
                    input logic [31:0] st, input logic [31:0] dt, input logic cl);
    wr(`ASR_OFF_MODE, {27'h0, m});
    asr_line_model_inst.send(m, d, f);
    rc(`ASR_OFF_STAT, st);
    rc(`ASR_OFF_DATA, dt);
    if (cl) wr(`ASR_OFF_STAT, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [7:0] d;
    presetn = 1'b0;
    {psel, penable, pwrite, standby, module_stop, sck} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rc(`ASR_OFF_CTRL, 32'h2);
    rc(`ASR_OFF_MODE, 32'h0);
    rc(`ASR_OFF_DIV, 32'h364);
    rc(`ASR_OFF_STAT, 32'h0);
    rc(`ASR_OFF_DATA, 32'h0);
    rc(8'h18, 32'h0);
    chk("pslverr", {31'h0, err}, 32'h1);
    rc(`ASR_OFF_PORT, 32'h1);
    chk("pslverr", {31'h0, err}, 32'h0);
    wr(`ASR_OFF_DIV, 32'(DIV));
    wr(`ASR_OFF_CTRL, 32'h3);
    for (int k = 0; k < 16; k++) begin
      d = 8'hC3 ^ k[7:0];
      if (k[2:1] != 2'b10) rx(k[4:0], d, 4'hC, 32'h1, {24'h0, d[7] & !k[0], d[6:0]}, 1);
    end
    rx(5'h10, 8'h5A, 4'h6, 32'h11, 32'h5A, 1);
    rx(5'h10, 8'h5A, 4'h4, 32'h01, 32'h5A, 1);
    rx(5'h02, 8'h3C, 4'h5, 32'h08, 32'h3C, 1);
    rx(5'h06, 8'h3D, 4'h5, 32'h08, 32'h3D, 1);
    rx(5'h08, 8'hA5, 4'h8, 32'h04, 32'hA5, 1);
    rx(5'h00, 8'h96, 4'h0, 32'h04, 32'h96, 0);
    rx(5'h00, 8'h69, 4'h4, 32'h04, 32'h96, 0);
    wr(`ASR_OFF_CTRL, 32'h2);
    rc(`ASR_OFF_STAT, 32'h4);
    wr(`ASR_OFF_CTRL, 32'h3);
    wr(`ASR_OFF_STAT, 32'h4);
    wr(`ASR_OFF_STAT, 32'h0);
    rc(`ASR_OFF_STAT, 32'h4);
    wr(`ASR_OFF_STAT, 32'h0);
    rc(`ASR_OFF_STAT, 32'h0);
    for (int i = 1; i < 5; i++) asr_line_model_inst.send(5'h0, i[7:0], 4'h4);
    rc(`ASR_OFF_STAT, 32'h3);
    for (int i = 1; i < 4; i++) begin
      rc(`ASR_OFF_DATA, 32'(i));
      wr(`ASR_OFF_STAT, 32'h0);
      rc(`ASR_OFF_STAT, i < 3 ? 32'h1 : 32'h0);
    end
    // synchronous mode: eight bits on rising sck, lsb first
    d = 8'hA6;
    wr(`ASR_OFF_CTRL, 32'h1);
    for (int j = 0; j < 8; j++) begin
      asr_line_model_inst.level(d[j]);
      @(posedge pclk);
      sck <= 1'b1;
      repeat (2) @(posedge pclk);
      sck <= 1'b0;
    end
    asr_line_model_inst.level(1'b1);
    wr(`ASR_OFF_CTRL, 32'h3);
    rc(`ASR_OFF_STAT, 32'h1);
    rc(`ASR_OFF_DATA, 32'hA6);
    wr(`ASR_OFF_STAT, 32'h0);
    rc(`ASR_OFF_STAT, 32'h0);
    for (int s = 0; s < 2; s++) begin
      asr_line_model_inst.send(5'h0, 8'h0, 4'h0);
      asr_line_model_inst.level(1'b0);
      repeat (12) @(posedge pclk);
      rc(`ASR_OFF_STAT, 32'h4);
      rc(`ASR_OFF_PORT, 32'h0);
      asr_line_model_inst.level(1'b1);
      {module_stop, standby} <= s ? 2'b10 : 2'b01;
      @(posedge pclk);
      rc(`ASR_OFF_STAT, 32'h0);
      {module_stop, standby} <= 2'b00;
    end
    wrap_up();
  end
endmodule
`default_nettype wire
